//--- logic/wdt_config.sv
`timescale 1ns/10ps
module wdt_config #(
    parameter int CYC_PER_SEC = wdt_pkg::CYC_PER_SEC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // host i/o port cycle, one-cycle strobes
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    output logic [7:0] io_rdata,
    // keyboard and mouse activity pins
    input wire logic kbd_irq,
    input wire logic mouse_irq,
    // watchdog output, pin routing and config lock status
    output logic watchdog_output_pin,
    output logic wdt_pin_routed,
    output logic config_unlocked
);
    import wdt_pkg::*;

    typedef struct packed {
        logic unlocked;
        logic half_key;
        logic [7:0] index;
        logic [7:0] ldev;
        logic [7:0] pinmux;
        logic act;
        logic [7:0] unit;
        logic [7:0] timeout;
        logic [7:0] count;
        logic [7:0] retrig;
        logic expired;
        logic [7:0] rdata;
        logic [1:0] kbd_sync;
        logic [1:0] mouse_sync;
        logic kbd_prev;
        logic mouse_prev;
    } cfg_state_t;

    cfg_state_t s_q, s_d;
    logic unit_tick;
    logic restart;
    logic running;
    logic idx_wr;
    logic dat_wr;
    logic dat_rd;
    logic wdt_sel;
    logic kbd_edge;
    logic mouse_edge;
    logic input_kick;
    logic tout_wr;

    assign idx_wr = io_wr && io_addr == PORT_INDEX;
    assign dat_wr = io_wr && io_addr == PORT_DATA && s_q.unlocked;
    assign dat_rd = io_rd && io_addr == PORT_DATA && s_q.unlocked;
    assign wdt_sel = s_q.ldev == LDEV_WDT;
    assign kbd_edge = s_q.kbd_sync[1] && !s_q.kbd_prev;
    assign mouse_edge = s_q.mouse_sync[1] && !s_q.mouse_prev;
    assign input_kick = (kbd_edge && s_q.retrig[RETRIG_KBD_BIT])
        || (mouse_edge && s_q.retrig[RETRIG_MOUSE_BIT]);
    assign tout_wr = dat_wr && wdt_sel && s_q.index == IDX_TIMEOUT;
    assign running = s_q.act && s_q.count != 8'h00;
    assign restart = tout_wr || (input_kick && running);

    wdt_tick #(
        .CYC_PER_SEC(CYC_PER_SEC),
        .SEC_PER_MIN(SEC_PER_MIN)
    ) i_wdt_tick (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(running),
        .minutes(s_q.unit[UNIT_BIT]),
        .restart(restart),
        .unit_tick(unit_tick)
    );

    always_comb begin
        s_d = s_q;
        s_d.kbd_sync = {s_q.kbd_sync[0], kbd_irq};
        s_d.mouse_sync = {s_q.mouse_sync[0], mouse_irq};
        s_d.kbd_prev = s_q.kbd_sync[1];
        s_d.mouse_prev = s_q.mouse_sync[1];
        if (idx_wr) begin
            if (!s_q.unlocked) begin
                if (io_wdata == KEY_ENTER && s_q.half_key) begin
                    s_d.unlocked = 1'b1;
                    s_d.half_key = 1'b0;
                end else begin
                    s_d.half_key = io_wdata == KEY_ENTER;
                end
            end else if (io_wdata == KEY_EXIT) begin
                s_d.unlocked = 1'b0;
                s_d.half_key = 1'b0;
            end else begin
                s_d.index = io_wdata;
            end
        end
        if (io_wr && io_addr != PORT_INDEX) begin
            s_d.half_key = 1'b0;
        end
        if (dat_wr) begin
            case (s_q.index)
                IDX_LDEV: s_d.ldev = io_wdata;
                IDX_PINMUX: s_d.pinmux = io_wdata;
                default: begin
                    if (wdt_sel) begin
                        if (s_q.index == IDX_ACTIVATE) begin
                            s_d.act = io_wdata[ACT_BIT];
                        end
                        if (s_q.index == IDX_UNIT) begin
                            s_d.unit = io_wdata;
                        end
                        if (s_q.index == IDX_RETRIG) begin
                            s_d.retrig = io_wdata;
                        end
                    end
                end
            endcase
        end
        // countdown
        if (tout_wr) begin
            s_d.timeout = io_wdata;
            s_d.count = io_wdata;
            s_d.expired = 1'b0;
        end else if (input_kick && running) begin
            s_d.count = s_q.timeout;
        end else if (running && unit_tick) begin
            s_d.count = s_q.count - 8'h01;
            if (s_q.count == 8'h01) begin
                s_d.expired = 1'b1;
            end
        end
        if (dat_rd) begin
            case (s_q.index)
                IDX_LDEV: s_d.rdata = s_q.ldev;
                IDX_PINMUX: s_d.rdata = s_q.pinmux;
                IDX_ACTIVATE: s_d.rdata = wdt_sel ? {7'h00, s_q.act} : 8'h00;
                IDX_UNIT: s_d.rdata = wdt_sel ? s_q.unit : 8'h00;
                IDX_TIMEOUT: s_d.rdata = wdt_sel ? s_q.count : 8'h00;
                IDX_RETRIG: s_d.rdata = wdt_sel ? s_q.retrig : 8'h00;
                default: s_d.rdata = 8'h00;
            endcase
        end else if (io_rd && io_addr == PORT_INDEX) begin
            s_d.rdata = s_q.unlocked ? s_q.index : 8'hff;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.pinmux <= RST_PINMUX;
            s_q.unit <= RST_ZERO;
            s_q.timeout <= RST_ZERO;
            s_q.count <= RST_ZERO;
            s_q.retrig <= RST_RETRIG;
        end else begin
            s_q <= s_d;
        end
    end

    assign io_rdata = s_q.rdata;
    assign wdt_pin_routed = !s_q.pinmux[PINMUX_WDT_BIT];
    assign watchdog_output_pin = s_q.expired && wdt_pin_routed;
    assign config_unlocked = s_q.unlocked;
endmodule : wdt_config

//--- logic/wdt_pkg.sv
// How it works
// - count only while watchdog device active
// - expiry asserts watchdog output pin
// - retrigger restarts full programmed interval
// - nonzero timeout write enables or refreshes
// - reset fires when count reaches zero
// - zero timeout write disables at once
// - count_unit_bit selects seconds or minutes
// - expiry exact to one clock, tick restarts on write or kick
// - index port selects, data port accesses
// - two consecutive 0x87 writes unlock config
// - 0xaa on index port locks config
// - index 0x07 picks device, 0x08 watchdog
// - 0x01 at index 0x30 activates watchdog
// - bit6 clear at 0x2c routes watchdog pin
// - timeout value lives at index 0xf6
// - 0x00 at 0xf7 stops input retrigger
package wdt_pkg;
    localparam logic [7:0] PORT_INDEX = 8'h2e;
    localparam logic [7:0] PORT_DATA = 8'h2f;
    localparam logic [7:0] KEY_ENTER = 8'h87;
    localparam logic [7:0] KEY_EXIT = 8'haa;
    localparam logic [7:0] IDX_LDEV = 8'h07;
    localparam logic [7:0] IDX_PINMUX = 8'h2c;
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] IDX_UNIT = 8'hf5;
    localparam logic [7:0] IDX_TIMEOUT = 8'hf6;
    localparam logic [7:0] IDX_RETRIG = 8'hf7;
    localparam logic [7:0] LDEV_WDT = 8'h08;
    localparam int UNIT_BIT = 3;
    localparam int PINMUX_WDT_BIT = 6;
    localparam int ACT_BIT = 0;
    localparam int RETRIG_KBD_BIT = 6;
    localparam int RETRIG_MOUSE_BIT = 7;
    localparam logic [7:0] RST_PINMUX = 8'h40;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_RETRIG = 8'hc0;
    localparam int CLK_HZ = 25000000;
    localparam int SEC_PER_MIN = 60;
    localparam int CYC_PER_SEC = CLK_HZ;
endpackage : wdt_pkg

//--- logic/wdt_tick.sv
`timescale 1ns/10ps
module wdt_tick #(
    parameter int CYC_PER_SEC = 25000000,
    parameter int SEC_PER_MIN = 60
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic minutes,
    input wire logic restart,
    // unit pulse
    output logic unit_tick
);
    typedef struct packed {
        logic [31:0] cyc;
        logic [7:0] sec;
        logic tick;
    } tick_state_t;
    tick_state_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run || restart) begin
            s_d.cyc = '0;
            s_d.sec = '0;
        end else if (s_q.cyc == 32'(CYC_PER_SEC - 1)) begin
            s_d.cyc = '0;
            if (!minutes) begin
                s_d.tick = 1'b1;
                s_d.sec = '0;
            end else if (s_q.sec == 8'(SEC_PER_MIN - 1)) begin
                s_d.tick = 1'b1;
                s_d.sec = '0;
            end else begin
                s_d.sec = s_q.sec + 8'h01;
            end
        end else begin
            s_d.cyc = s_q.cyc + 32'h1;
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign unit_tick = s_q.tick;
endmodule : wdt_tick

//--- sim/wdt_config_chk.sv
`timescale 1ns/10ps
module wdt_config_chk #(
    parameter int CYC_PER_SEC = wdt_pkg::CYC_PER_SEC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // host port and pins
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_rdata,
    input wire logic kbd_irq,
    input wire logic mouse_irq,
    input wire logic watchdog_output_pin,
    input wire logic wdt_pin_routed,
    input wire logic config_unlocked
);
    import wdt_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [7:0] idx_q, ldev_q;
    logic first_q, idx_wr, to_wr;
    int age_q;
    assign idx_wr = io_wr && io_addr == PORT_INDEX;
    assign to_wr = io_wr && io_addr == PORT_DATA && config_unlocked && idx_q == IDX_TIMEOUT
        && ldev_q == LDEV_WDT;
    // mirror of index, device select and time since last timeout write
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            idx_q <= 8'h00;
            ldev_q <= 8'h00;
            first_q <= 1'b0;
            age_q <= 0;
        end else begin
            if (idx_wr && config_unlocked && io_wdata != KEY_EXIT) begin
                idx_q <= io_wdata;
            end
            if (io_wr && io_addr == PORT_DATA && config_unlocked && idx_q == IDX_LDEV) begin
                ldev_q <= io_wdata;
            end
            if (io_wr) begin
                first_q <= idx_wr && io_wdata == KEY_ENTER;
            end
            age_q <= to_wr ? 0 : (age_q < CYC_PER_SEC ? age_q + 1 : age_q);
        end
    end
    AST_UNLOCK: assert property (idx_wr && io_wdata == KEY_ENTER && first_q |=> config_unlocked)
        else $error("config not unlocked");
    AST_STAY_LOCKED: assert property (!config_unlocked && !(idx_wr && io_wdata == KEY_ENTER)
        |=> !config_unlocked) else $error("config opened early");
    AST_LOCK: assert property (idx_wr && io_wdata == KEY_EXIT |=> !config_unlocked)
        else $error("config not locked");
    AST_LOCKED_INDEX: assert property (io_rd && io_addr == PORT_INDEX && !config_unlocked
        |=> io_rdata == 8'hff) else $error("locked index read wrong");
    AST_RDATA_HOLD: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data moved");
    AST_ROUTED: assert property (watchdog_output_pin |-> wdt_pin_routed)
        else $error("pin high while not routed");
    AST_PIN_HOLD: assert property (watchdog_output_pin && !io_wr |=> watchdog_output_pin)
        else $error("expiry output dropped");
    AST_ZERO_OFF: assert property (to_wr && io_wdata == 8'h00 |=> !watchdog_output_pin [*8])
        else $error("zero write did not disable");
    AST_FULL_UNIT: assert property (watchdog_output_pin |-> age_q >= CYC_PER_SEC)
        else $error("expired before one unit");
    cover property ($rose(watchdog_output_pin));
    cover property (to_wr && io_wdata == 8'h00);
    cover property ($rose(config_unlocked));
endmodule : wdt_config_chk
bind wdt_config wdt_config_chk #(.CYC_PER_SEC(CYC_PER_SEC)) i_wdt_config_chk (.*);

//--- sim/wdt_host.sv
`timescale 1ns/10ps
module wdt_host (
    // clock
    input wire logic clk_sys,
    // host port cycle
    output logic [7:0] io_addr,
    output logic [7:0] io_wdata,
    output logic io_wr,
    output logic io_rd,
    input wire logic [7:0] io_rdata
);
    initial begin
        io_addr = 8'h00;
        io_wdata = 8'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
    end
    // one strobed port cycle, lines turned over once released
    task automatic cyc(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge clk_sys);
        #1;
        io_addr = a;
        io_wdata = d;
        io_wr = w;
        io_rd = !w;
        @(posedge clk_sys);
        #1;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = ~a;
        io_wdata = ~d;
    endtask : cyc
endmodule : wdt_host

//--- sim/tb_wdt_config.sv
`timescale 1ns/10ps
module tb_wdt_config;
    import wdt_pkg::*;
    localparam int CPS = 10;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic kbd_irq = 1'b0;
    logic mouse_irq = 1'b0;
    logic [7:0] io_addr, io_wdata, io_rdata;
    logic io_wr, io_rd, watchdog_output_pin, wdt_pin_routed, config_unlocked;
    int errors = 0;
    int n_compared = 0;
    always #20 clk_sys = ~clk_sys;
    wdt_config #(.CYC_PER_SEC(CPS)) i_wdt_config (.*);
    wdt_host i_wdt_host (.*);
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic cfg(input logic [7:0] idx, input logic [7:0] val);
        i_wdt_host.cyc(PORT_INDEX, idx, 1'b1);
        i_wdt_host.cyc(PORT_DATA, val, 1'b1);
    endtask : cfg
    task automatic cget(input logic [7:0] idx, input logic [7:0] exp);
        i_wdt_host.cyc(PORT_INDEX, idx, 1'b1);
        i_wdt_host.cyc(PORT_DATA, 8'h00, 1'b0);
        chk("config read", io_rdata, exp);
    endtask : cget
    task automatic expire(input int n);
        tick(n);
        chk("pin early", watchdog_output_pin, 8'h00);
        tick(1);
        chk("pin late", watchdog_output_pin, 8'h01);
    endtask : expire
    task automatic tally_and_finish;
        if (errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        tick(16);
        rst = 1'b0;
        i_wdt_host.cyc(PORT_INDEX, 8'h00, 1'b0);
        chk("locked index", io_rdata, 8'hff);
        i_wdt_host.cyc(PORT_INDEX, KEY_ENTER, 1'b1);
        i_wdt_host.cyc(PORT_INDEX, KEY_ENTER, 1'b1);
        chk("unlocked", config_unlocked, 8'h01);
        cget(IDX_PINMUX, RST_PINMUX);
        cfg(IDX_PINMUX, RST_PINMUX & 8'hbf);
        chk("routed", wdt_pin_routed, 8'h01);
        cfg(IDX_LDEV, LDEV_WDT);
        cfg(IDX_ACTIVATE, 8'h01);
        cfg(IDX_UNIT, 8'h00);
        cfg(IDX_RETRIG, 8'h00);
        cfg(IDX_TIMEOUT, 8'h03);
        tick(2 * CPS);
        cfg(IDX_TIMEOUT, 8'h03);
        kbd_irq = 1'b1;
        expire(3 * CPS);
        cget(IDX_TIMEOUT, 8'h00);
        cfg(IDX_TIMEOUT, 8'h02);
        tick(CPS + 2);
        cget(IDX_TIMEOUT, 8'h01);
        cfg(IDX_TIMEOUT, 8'h00);
        tick(4 * CPS);
        chk("pin off", watchdog_output_pin, 8'h00);
        cfg(IDX_ACTIVATE, 8'h00);
        cfg(IDX_TIMEOUT, 8'h01);
        tick(3 * CPS);
        chk("inactive", watchdog_output_pin, 8'h00);
        cfg(IDX_ACTIVATE, 8'h01);
        cfg(IDX_UNIT, 8'h08);
        cget(IDX_UNIT, 8'h08);
        cfg(IDX_TIMEOUT, 8'h01);
        expire(SEC_PER_MIN * CPS);
        cfg(IDX_UNIT, 8'h00);
        cfg(IDX_RETRIG, 8'h80);
        cfg(IDX_TIMEOUT, 8'h01);
        tick(5);
        mouse_irq = 1'b1;
        expire(CPS + 3);
        i_wdt_host.cyc(PORT_INDEX, KEY_EXIT, 1'b1);
        chk("locked", config_unlocked, 8'h00);
        i_wdt_host.cyc(PORT_DATA, 8'h00, 1'b1);
        chk("pin kept", watchdog_output_pin, 8'h01);
        tally_and_finish();
    end
    initial begin
        #(40 * 3000);
        errors++;
        tally_and_finish();
    end
endmodule : tb_wdt_config
